// *** rtl/ietd_delay.sv ***
// One channel's ON/OFF delay stage for an event status.
`timescale 1ns/1ps
`default_nettype none
module ietd_delay
  import ietd_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Channel controls
  input wire logic raw,
  input wire logic enable,
  input wire logic bypass,
  input wire logic [1:0] unit,
  input wire logic [13:0] on_dly,
  input wire logic [13:0] off_dly,
  // Timebase pulses
  input wire logic tick_tenth,
  input wire logic tick_sec,
  input wire logic tick_min,
  // Delayed status
  output logic status
);

  ietd_dly_st_t q, d;
  logic tick;
  logic [13:0] dly;

  // ********************************************************************
  // Next state
  // ********************************************************************
  // The delay is counted in whole ticks, so the first tick may come early
  // by up to one unit; this matches a software scan of the same timebase.
  always_comb begin
    d = q;
    case (unit)
      IETD_UNIT_TENTH: tick = tick_tenth;
      IETD_UNIT_SEC: tick = tick_sec;
      IETD_UNIT_MIN: tick = tick_min;
      default: tick = tick_sec;
    endcase
    dly = q.status ? off_dly : on_dly;
    if (!enable) begin
      d.status = 1'b0;
      d.cnt = 14'h0000;
    end else if (raw == q.status) begin
      d.cnt = 14'h0000;
    end else if (bypass || dly == 14'h0000) begin
      d.status = raw;
      d.cnt = 14'h0000;
    end else if (tick) begin
      if (q.cnt + 14'h0001 >= dly) begin
        d.status = raw;
        d.cnt = 14'h0000;
      end else begin
        d.cnt = q.cnt + 14'h0001;
      end
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign status = q.status;

endmodule
`default_nettype wire

// *** rtl/ietd_event_timing.sv ***
// Register file, timebase and delay stages for five internal event channels.
//
// Operation
// - main threshold -1999..+9999, reset zero.
// - some operation types force non-negative thresholds.
// - sub-threshold -1999..+9999, reset zero.
// - hysteresis 0..9999, reset five.
// - decimal position follows PV per operation type.
// - type zero hides and disables thresholds.
// - ON delay postpones status turning on.
// - OFF delay postpones status turning off.
// - tenth-second unit spans 0.0..999.9 s.
// - other units span 0..9999 counts.
// - loop diagnosis and timer bypass delays.
// - type zero hides and disables delays.
// - unit code 0 tenths, 1 seconds, 2 minutes.
`timescale 1ns/1ps
`default_nettype none
module ietd_event_timing
  import ietd_pkg::*;
#(
  parameter int TENTH_CYCLES = IETD_TENTH_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire ietd_apb_req_t apb_req,
  output ietd_apb_rsp_t apb_rsp,
  // Process value decimal places and raw event conditions
  input wire logic [1:0] pv_decimals,
  input wire logic [4:0] raw_event,
  // Effective settings for the comparators and delayed status
  output ietd_thr_t [4:0] thr_out,
  output logic [4:0] event_status
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    ietd_chan_t [4:0] ch;
    ietd_thr_t [4:0] thr;
    ietd_apb_rsp_t rsp;
    logic [23:0] div;
    logic [3:0] tenths;
    logic [5:0] secs;
    logic tick_t;
    logic tick_s;
    logic tick_m;
  } ietd_top_st_t;

  ietd_top_st_t q, d;
  logic acc;
  logic hit_ch;
  logic hit_st;
  logic [2:0] sel;
  logic [2:0] rg;
  logic [4:0] ev;

  // True when an operation type restricts thresholds to 0..9999.
  function automatic logic op_unsigned(input logic [5:0] op);
    return op >= IETD_OP_UNS_LO && op <= IETD_OP_UNS_HI;
  endfunction

  // True when an operation type compares against the process value.
  function automatic logic op_uses_pv(input logic [5:0] op);
    return op >= IETD_OP_PV_LO && op <= IETD_OP_PV_HI;
  endfunction

  // True when the delay fields serve another function.
  function automatic logic op_no_delay(input logic [5:0] op);
    return (op >= IETD_OP_LOOP1 && op <= IETD_OP_LOOP3) ||
           op == IETD_OP_TIMER;
  endfunction

  // Threshold as seen by the comparator for a given type.
  function automatic logic [15:0] eff_thr(input logic [15:0] v,
                                          input logic [5:0] op);
    if (op == IETD_OP_NONE) return 16'h0000;
    if (op_unsigned(op) && v[15]) return 16'h0000;
    return v;
  endfunction

  // ********************************************************************
  // Address decode
  // ********************************************************************
  // Channel registers sit at channel*0x20 plus a word offset; only whole
  // aligned words inside the map are accepted, anything else errors.
  always_comb begin
    sel = apb_req.paddr[7:5];
    rg = apb_req.paddr[4:2];
    hit_st = apb_req.paddr == IETD_STATUS_ADDR;
    hit_ch = apb_req.paddr[11:8] == 4'h0 &&
             apb_req.paddr[1:0] == 2'h0 &&
             sel < 3'h5 && rg <= IETD_REG_CFG;
  end

  assign acc = apb_req.psel & apb_req.penable;

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    d = q;

    // Timebase: a tenth-second pulse, and seconds and minutes from it.
    d.tick_t = 1'b0;
    d.tick_s = 1'b0;
    d.tick_m = 1'b0;
    if (q.div == 24'(TENTH_CYCLES - 1)) begin
      d.div = 24'h000000;
      d.tick_t = 1'b1;
      if (q.tenths == IETD_TENTHS_PER_SEC - 4'h1) begin
        d.tenths = 4'h0;
        d.tick_s = 1'b1;
        if (q.secs == IETD_SECS_PER_MIN - 6'h01) begin
          d.secs = 6'h00;
          d.tick_m = 1'b1;
        end else begin
          d.secs = q.secs + 6'h01;
        end
      end else begin
        d.tenths = q.tenths + 4'h1;
      end
    end else begin
      d.div = q.div + 24'h000001;
    end

    // APB: one wait state, so read data and pready both leave flops.
    d.rsp.pready = acc & ~q.rsp.pready;
    if (acc && !q.rsp.pready) begin
      d.rsp.pslverr = ~(hit_ch | hit_st);
      d.rsp.prdata = 32'h00000000;
      if (hit_st) begin
        d.rsp.prdata = {22'h000000, pv_decimals, 3'h0, ev};
      end else if (hit_ch) begin
        // Fields of a channel of type zero read as zero, except the config word.
        if (q.ch[sel].op != IETD_OP_NONE || rg == IETD_REG_CFG) begin
          case (rg)
            IETD_REG_MAIN:
              d.rsp.prdata = {{16{q.ch[sel].main[15]}}, q.ch[sel].main};
            IETD_REG_SUB:
              d.rsp.prdata = {{16{q.ch[sel].sub[15]}}, q.ch[sel].sub};
            IETD_REG_HYS: d.rsp.prdata = {16'h0000, q.ch[sel].hys};
            IETD_REG_ON: d.rsp.prdata = {18'h00000, q.ch[sel].on_dly};
            IETD_REG_OFF: d.rsp.prdata = {18'h00000, q.ch[sel].off_dly};
            IETD_REG_CFG: d.rsp.prdata = {18'h00000, q.thr[sel].dp,
                                          2'h0, q.ch[sel].unit,
                                          2'h0, q.ch[sel].op};
            default: d.rsp.prdata = 32'h00000000;
          endcase
        end
      end
    end else begin
      // The answer stands for one cycle only, so an error flag or read data
      // must not linger once pready has dropped.
      d.rsp.pslverr = 1'b0;
      d.rsp.prdata = 32'h00000000;
    end

    // Writes land on the edge that completes the access.
    if (acc && q.rsp.pready && apb_req.pwrite && hit_ch) begin
      case (rg)
        IETD_REG_MAIN:
          d.ch[sel].main = ietd_clamp_thr(apb_req.pwdata);
        IETD_REG_SUB:
          d.ch[sel].sub = ietd_clamp_thr(apb_req.pwdata);
        IETD_REG_HYS:
          d.ch[sel].hys = {2'h0, ietd_clamp_u(apb_req.pwdata)};
        IETD_REG_ON:
          d.ch[sel].on_dly = ietd_clamp_u(apb_req.pwdata);
        IETD_REG_OFF:
          d.ch[sel].off_dly = ietd_clamp_u(apb_req.pwdata);
        IETD_REG_CFG: begin
          d.ch[sel].op = apb_req.pwdata[5:0];
          // A reserved unit code is taken as minutes, the longest unit.
          if (apb_req.pwdata[9:8] == 2'h3) begin
            d.ch[sel].unit = IETD_UNIT_MIN;
          end else begin
            d.ch[sel].unit = apb_req.pwdata[9:8];
          end
        end
        default: d.ch[sel].op = q.ch[sel].op;
      endcase
    end

    // Effective settings handed to the comparators, one per channel.
    for (int i = 0; i < IETD_NCH; i++) begin
      d.thr[i].main = eff_thr(q.ch[i].main, q.ch[i].op);
      d.thr[i].sub = eff_thr(q.ch[i].sub, q.ch[i].op);
      d.thr[i].hys = (q.ch[i].op == IETD_OP_NONE) ?
                     16'h0000 : q.ch[i].hys;
      d.thr[i].dp = op_uses_pv(q.ch[i].op) ? pv_decimals : 2'h0;
    end
  end

  // ********************************************************************
  // State register
  // ********************************************************************
  // Reset loads the documented initial settings for every channel.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      for (int i = 0; i < IETD_NCH; i++) begin
        q.ch[i].main <= IETD_THR_RST;
        q.ch[i].sub <= IETD_THR_RST;
        q.ch[i].hys <= IETD_HYS_RST;
        q.ch[i].on_dly <= IETD_DLY_RST;
        q.ch[i].off_dly <= IETD_DLY_RST;
        q.ch[i].unit <= IETD_UNIT_TENTH;
        q.ch[i].op <= IETD_OP_NONE;
      end
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // Delay stages
  // ********************************************************************
  // Each stage owns the flop that drives its status output.
  for (genvar g = 0; g < IETD_NCH; g++) begin : g_dly
    ietd_delay u_dly (
      .pclk(pclk),
      .presetn(presetn),
      .raw(raw_event[g]),
      .enable(q.ch[g].op != IETD_OP_NONE),
      .bypass(op_no_delay(q.ch[g].op)),
      .unit(q.ch[g].unit),
      .on_dly(q.ch[g].on_dly),
      .off_dly(q.ch[g].off_dly),
      .tick_tenth(q.tick_t),
      .tick_sec(q.tick_s),
      .tick_min(q.tick_m),
      .status(ev[g])
    );
  end

  // Outputs, all from flops.
  assign apb_rsp = q.rsp;
  assign thr_out = q.thr;
  assign event_status = ev;

endmodule
`default_nettype wire

// *** rtl/ietd_pkg.sv ***
// Package of constants, types and helpers for the event threshold/delay block.
package ietd_pkg;

  // ********************************************************************
  // Geometry and limits
  // ********************************************************************
  localparam int IETD_NCH = 5;
  localparam logic [15:0] IETD_THR_MIN = 16'hf831; // -1999
  localparam logic [15:0] IETD_THR_MAX = 16'h270f; // +9999
  localparam logic [15:0] IETD_THR_RST = 16'h0000;
  localparam logic [15:0] IETD_HYS_RST = 16'h0005;
  localparam logic [13:0] IETD_DLY_MAX = 14'h270f; // 9999 counts
  localparam logic [13:0] IETD_DLY_RST = 14'h0000;

  // ********************************************************************
  // Operation types and delay units
  // ********************************************************************
  localparam logic [5:0] IETD_OP_NONE = 6'h00;
  localparam logic [5:0] IETD_OP_LOOP1 = 6'h14;
  localparam logic [5:0] IETD_OP_LOOP3 = 6'h16;
  localparam logic [5:0] IETD_OP_TIMER = 6'h20;
  localparam logic [5:0] IETD_OP_UNS_LO = 6'h09;
  localparam logic [5:0] IETD_OP_UNS_HI = 6'h0c;
  localparam logic [5:0] IETD_OP_PV_LO = 6'h01;
  localparam logic [5:0] IETD_OP_PV_HI = 6'h0c;
  localparam logic [1:0] IETD_UNIT_TENTH = 2'h0;
  localparam logic [1:0] IETD_UNIT_SEC = 2'h1;
  localparam logic [1:0] IETD_UNIT_MIN = 2'h2;

  // ********************************************************************
  // Timebase
  // ********************************************************************
  localparam int IETD_CLK_NS = 10;
  localparam int IETD_TENTH_NS = 100_000_000;
  localparam int IETD_TENTH_CYC = IETD_TENTH_NS / IETD_CLK_NS;
  localparam logic [3:0] IETD_TENTHS_PER_SEC = 4'ha;
  localparam logic [5:0] IETD_SECS_PER_MIN = 6'h3c;

  // ********************************************************************
  // Register map (word offsets within a channel, status byte address)
  // ********************************************************************
  localparam logic [2:0] IETD_REG_MAIN = 3'h0;
  localparam logic [2:0] IETD_REG_SUB = 3'h1;
  localparam logic [2:0] IETD_REG_HYS = 3'h2;
  localparam logic [2:0] IETD_REG_ON = 3'h3;
  localparam logic [2:0] IETD_REG_OFF = 3'h4;
  localparam logic [2:0] IETD_REG_CFG = 3'h5;
  localparam int IETD_CH_LSB = 5; // 0x20 bytes per channel
  localparam logic [11:0] IETD_STATUS_ADDR = 12'h100;

  // ********************************************************************
  // Types
  // ********************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ietd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ietd_apb_rsp_t;

  typedef struct packed {
    logic [15:0] main;
    logic [15:0] sub;
    logic [15:0] hys;
    logic [13:0] on_dly;
    logic [13:0] off_dly;
    logic [5:0] op;
    logic [1:0] unit;
  } ietd_chan_t;

  typedef struct packed {
    logic [15:0] main;
    logic [15:0] sub;
    logic [15:0] hys;
    logic [1:0] dp;
  } ietd_thr_t;

  typedef struct packed {
    logic status;
    logic [13:0] cnt;
  } ietd_dly_st_t;

  // Clamp a signed write value into -1999..+9999.
  function automatic logic [15:0] ietd_clamp_thr(input logic [31:0] w);
    if ($signed(w) < $signed(32'hfffff831)) return IETD_THR_MIN;
    if ($signed(w) > $signed(32'h0000270f)) return IETD_THR_MAX;
    return w[15:0];
  endfunction

  // Clamp an unsigned write value into 0..9999.
  function automatic logic [13:0] ietd_clamp_u(input logic [31:0] w);
    if ($signed(w) < 0) return 14'h0000;
    if (w > 32'h0000270f) return IETD_DLY_MAX;
    return w[13:0];
  endfunction

endpackage

// *** test/ietd_event_timing_properties.sv ***
// Port checker for the event threshold and delay block.
`timescale 1ns/1ps
`default_nettype none
module ietd_event_timing_properties
  import ietd_pkg::*;
#(
  parameter int TENTH_CYCLES = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire ietd_apb_req_t apb_req,
  input wire ietd_apb_rsp_t apb_rsp,
  // Event side
  input wire logic [1:0] pv_decimals,
  input wire logic [4:0] raw_event,
  input wire ietd_thr_t [4:0] thr_out,
  input wire logic [4:0] event_status
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ********************************************************************
  // Bus handshake
  // ********************************************************************
  AST_ONE_WAIT: assert property (apb_req.psel && apb_req.penable &&
    !apb_rsp.pready |=> apb_rsp.pready) else $error("pready late");
  AST_READY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held");
  AST_READY_IN_ACCESS: assert property (apb_rsp.pready |->
    apb_req.psel && apb_req.penable) else $error("pready outside access");
  AST_ERR_WITH_READY: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
    else $error("pslverr without pready");
  AST_ERR_ZERO_DATA: assert property (apb_rsp.pslverr |->
    apb_rsp.prdata == 32'h00000000) else $error("error data not zero");

  // ********************************************************************
  // Status and settings
  // ********************************************************************
  // A status bit may only move towards the raw level seen one edge before.
  AST_STATUS_FROM_RAW: assert property (((event_status ^ $past(event_status))
    & (event_status ^ $past(raw_event))) == 5'h00) else $error("bad status");
  for (genvar i = 0; i < 5; i++) begin : g_ch
    AST_MAIN_RANGE: assert property ($signed(thr_out[i].main) >= -1999 &&
      $signed(thr_out[i].main) <= 9999) else $error("main out of range");
    AST_SUB_RANGE: assert property ($signed(thr_out[i].sub) >= -1999 &&
      $signed(thr_out[i].sub) <= 9999) else $error("sub out of range");
    AST_HYS_RANGE: assert property (thr_out[i].hys <= 16'h270f)
      else $error("hysteresis out of range");
  end
endmodule

bind ietd_event_timing ietd_event_timing_properties #(
  .TENTH_CYCLES(TENTH_CYCLES)
) chk_u (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .pv_decimals(pv_decimals),
  .raw_event(raw_event),
  .thr_out(thr_out),
  .event_status(event_status)
);
`default_nettype wire

// *** test/ietd_event_timing_test.sv ***
// Self-checking bench for the event threshold and delay block.
`timescale 1ns/1ps
`default_nettype none
module ietd_event_timing_test
  import ietd_pkg::*;
;
  // A short tenth keeps the minute case inside the run budget.
  localparam int TC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ietd_apb_req_t req = '0;
  ietd_apb_rsp_t rsp;
  logic [1:0] pv = 2'h2;
  logic [4:0] raw = 5'h00;
  ietd_thr_t [4:0] thr;
  logic [4:0] st;
  logic [31:0] rdv;
  logic errv;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;

  ietd_event_timing #(.TENTH_CYCLES(TC)) dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(req),
    .apb_rsp(rsp),
    .pv_decimals(pv),
    .raw_event(raw),
    .thr_out(thr),
    .event_status(st)
  );

  // ********************************************************************
  // Clock, timeout and helpers
  // ********************************************************************
  always #5 pclk = ~pclk;

  // A hang anywhere ends in the same report as a normal finish.
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; outputs are read at the edge that samples pready.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (rsp.pready !== 1'b1);
    rdv = rsp.prdata;
    errv = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  function automatic logic [11:0] ad(input int c, input logic [2:0] r);
    return 12'(c << IETD_CH_LSB) | {7'h00, r, 2'b00};
  endfunction

  function automatic logic [31:0] cfg(input logic [5:0] op,
                                      input logic [1:0] u);
    return {22'h0, u, 2'h0, op};
  endfunction

  task automatic wr(input int c, input logic [2:0] r, input logic [31:0] d);
    xfer(1'b1, ad(c, r), d);
  endtask

  task automatic rd(input int c, input logic [2:0] r, input logic [31:0] e,
                    input string nm);
    xfer(1'b0, ad(c, r), 32'h0);
    chk(nm, e, rdv);
  endtask

  task automatic wait_st(input int c, input logic v, output int n);
    n = 0;
    while (st[c] !== v && n < 20000) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // ********************************************************************
  // Tests
  // ********************************************************************
  initial begin
    int n;
    int uc;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 5; c++) begin
      rd(c, IETD_REG_HYS, 32'h0, "hys hidden");
      wr(c, IETD_REG_CFG, cfg(IETD_OP_PV_LO, IETD_UNIT_TENTH));
      rd(c, IETD_REG_MAIN, 32'h0, "main reset");
      rd(c, IETD_REG_SUB, 32'h0, "sub reset");
      rd(c, IETD_REG_HYS, 32'h5, "hys reset");
      rd(c, IETD_REG_ON, 32'h0, "on reset");
      rd(c, IETD_REG_OFF, 32'h0, "off reset");
    end
    $display("test reset values done");
    wr(0, IETD_REG_MAIN, 32'hfffff448);
    rd(0, IETD_REG_MAIN, 32'hfffff831, "main clamp");
    wr(0, IETD_REG_SUB, 32'h00004e20);
    rd(0, IETD_REG_SUB, 32'h0000270f, "sub clamp");
    wr(0, IETD_REG_HYS, 32'hffffffff);
    rd(0, IETD_REG_HYS, 32'h0, "hys clamp");
    wr(0, IETD_REG_ON, 32'h0000270f);
    rd(0, IETD_REG_ON, 32'h0000270f, "on max");
    wr(0, IETD_REG_OFF, 32'h00004e20);
    rd(0, IETD_REG_OFF, 32'h0000270f, "off clamp");
    xfer(1'b0, 12'h018, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, errv});
    chk("unmapped data", 32'h0, rdv);
    chk("thr main", 32'h0000f831, {16'h0, thr[0].main});
    chk("dp follows pv", 32'h2, {30'h0, thr[0].dp});
    chk("thr sub", 32'h0000270f, {16'h0, thr[0].sub});
    wr(0, IETD_REG_CFG, cfg(IETD_OP_UNS_LO, IETD_UNIT_TENTH));
    repeat (2) @(posedge pclk);
    chk("thr nonneg", 32'h0, {16'h0, thr[0].main});
    $display("test ranges done");
    // Type zero keeps writes but hides them and keeps status low.
    wr(2, IETD_REG_CFG, 32'h0);
    wr(2, IETD_REG_MAIN, 32'h64);
    wr(2, IETD_REG_ON, 32'h5);
    rd(2, IETD_REG_MAIN, 32'h0, "main hidden");
    rd(2, IETD_REG_ON, 32'h0, "on hidden");
    chk("thr hidden", 32'h0, {16'h0, thr[2].main});
    chk("thr hys hidden", 32'h0, {16'h0, thr[2].hys});
    raw[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("status hidden", 32'h0, {31'h0, st[2]});
    raw[2] <= 1'b0;
    $display("test type zero done");
    // Loop diagnosis and timer types pass raw straight through.
    for (int c = 3; c < 5; c++) begin
      wr(c, IETD_REG_CFG, cfg(c == 3 ? IETD_OP_LOOP1 : IETD_OP_TIMER, 2'h0));
      wr(c, IETD_REG_ON, 32'h5);
      wr(c, IETD_REG_OFF, 32'h5);
      raw[c] <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("bypass on", 32'h1, {31'h0, st[c]});
      raw[c] <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("bypass off", 32'h0, {31'h0, st[c]});
    end
    chk("dp other op", 32'h0, {30'h0, thr[3].dp});
    $display("test bypass done");
    // Delay of two units in each unit; code 3 must land on minutes.
    for (int u = 0; u < 3; u++) begin
      uc = (u == 0) ? TC : (u == 1) ? TC * 10 : TC * 600;
      wr(u, IETD_REG_CFG, cfg(IETD_OP_PV_LO, u == 2 ? 2'h3 : 2'(u)));
      rd(u, IETD_REG_CFG, {18'h0, 2'h2, 2'h0, 2'(u), 8'h01}, "unit");
      wr(u, IETD_REG_ON, 32'h2);
      wr(u, IETD_REG_OFF, 32'h2);
      raw[u] <= 1'b1;
      wait_st(u, 1'b1, n);
      chk("on delay", 32'h1, {31'h0, n >= uc - 2 && n <= 2 * uc + 3});
      raw[u] <= 1'b0;
      wait_st(u, 1'b0, n);
      chk("off delay", 32'h1, {31'h0, n >= uc - 2 && n <= 2 * uc + 3});
    end
    $display("test delay units done");
    // A short drop of raw must restart the pending count.
    raw[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    raw[0] <= 1'b0;
    repeat (2) @(posedge pclk);
    raw[0] <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("restart", 32'h0, {31'h0, st[0]});
    wait_st(0, 1'b1, n);
    chk("late on", 32'h1, {31'h0, st[0]});
    // Only channel 0 is on now; the status word also carries pv.
    xfer(1'b0, IETD_STATUS_ADDR, 32'h0);
    chk("status reg", 32'h00000201, rdv);
    xfer(1'b1, IETD_STATUS_ADDR, 32'hffffffff);
    chk("status write err", 32'h0, {31'h0, errv});
    $display("test restart done");
    give_verdict();
  end
endmodule
`default_nettype wire
